// File: rtl/omc_pkg.sv
// package of constants and types for the operating-mode controller
package omc_pkg;
    // ************************************************************
    // modes and codes
    // ************************************************************
    typedef enum logic [2:0] {
        OMC_INIT,
        OMC_NORMAL,
        OMC_STOP,
        OMC_SLEEP,
        OMC_RESTART,
        OMC_FAILSAFE
    } omc_mode_type;

    // mode field codes as written by the host
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP  = 2'h1;
    localparam logic [1:0] MODE_STOP   = 2'h2;
    localparam logic [1:0] MODE_RESET  = 2'h3;

    localparam logic [1:0] MODE_FIELD_RST = 2'h0;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ           = 125;
    localparam int RESET_DELAY_US    = 10;
    localparam int RESET_DELAY_CYC   = RESET_DELAY_US * CLK_MHZ;
    localparam int DLY_W             = 12;
endpackage

// File: rtl/omc_ctrl.sv
// operating-mode state machine of the system basis chip
// Notes on behaviour
// - power-up or soft reset enters init
// - normal is home; stop keeps rail on
// - sleep switches the main rail off
// - wake in sleep or failsafe restarts
// - watchdog or undervoltage failure in normal or stop restarts
// - restart holds host in reset
// - after cleared failure plus delay, normal
// - thermal or rail short in normal, stop, sleep or restart enters failsafe
// - failsafe ends on wake without overtemperature
// - test pin low in init: development
// - development halts watchdog, all modes reachable
// - host configures over 16-bit spi
// - restart clears the mode field
// - any command in init goes normal, failsafe under overtemperature
// - wakes in init are discarded
// - stop to sleep: spi fail, restart
`timescale 1ns/1ns
`default_nettype none
module omc_ctrl
    import omc_pkg::*;
(
    input  wire logic       ref_clk,       // system clock
    input  wire logic       srst,          // sync reset, high
    input  wire logic       clk_en,        // freezes state when low
    input  wire logic       soft_rst,      // soft reset command pulse
    input  wire logic       cmd_valid,     // spi frame decoded, pulse
    input  wire logic       cmd_is_mode,   // frame writes mode field
    input  wire logic [1:0] cmd_mode,      // requested mode code
    input  wire logic       wake_pin,      // wake event, async level
    input  wire logic       test_pin,      // test pin, async, low=dev
    input  wire logic       wd_fail,       // watchdog failure pulse
    input  wire logic       rail_uv,       // main rail undervoltage
    input  wire logic       rail_short,    // main rail short to ground
    input  wire logic       thermal_shutdown_level_two, // overtemp
    output logic [2:0]      mode_state,    // current mode
    output logic [1:0]      mode_field,    // readable mode field
    output logic            main_supply_rail, // rail enable
    output logic            host_rst_n,    // host reset, active low
    output logic            dev_mode,      // development mode
    output logic            wd_halt,       // watchdog counter halted
    output logic            spi_fail,      // illegal request flag
    output logic            wake_seen      // wake acted on, pulse
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [1:0] wk_sync_ff, nxt_wk_sync;
    logic [1:0] tst_sync_ff, nxt_tst_sync;

    always_comb
    begin
        nxt_wk_sync  = {wk_sync_ff[0], wake_pin};
        nxt_tst_sync = {tst_sync_ff[0], test_pin};
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            wk_sync_ff  <= 2'h0;
            tst_sync_ff <= 2'h3;
        end
        else if (clk_en)
        begin
            wk_sync_ff  <= nxt_wk_sync;
            tst_sync_ff <= nxt_tst_sync;
        end
    end

    logic wake, test_low;
    assign wake     = wk_sync_ff[1];
    assign test_low = ~tst_sync_ff[1];

    // ************************************************************
    // mode machine
    // ************************************************************
    omc_mode_type    state_ff, nxt_state;
    logic [1:0]      field_ff, nxt_field;
    logic [DLY_W-1:0] dly_ff,  nxt_dly;
    logic            dev_ff,   nxt_dev;
    logic            fail_ff,  nxt_fail;
    logic            wseen_ff, nxt_wseen;
    logic            failure;

    // failure that must hold restart until it clears
    assign failure = rail_uv;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_field = field_ff;
        nxt_dly   = dly_ff;
        nxt_dev   = dev_ff;
        nxt_fail  = fail_ff;
        nxt_wseen = 1'b0;
        if (cmd_valid && cmd_is_mode && cmd_mode == MODE_RESET)
            nxt_field = field_ff;
        else if (cmd_valid && cmd_is_mode)
            nxt_field = cmd_mode;
        unique case (state_ff)
            OMC_INIT:
            begin
                if (test_low)
                    nxt_dev = 1'b1;
                if (cmd_valid)
                begin
                    nxt_state = OMC_NORMAL;
                    nxt_field = MODE_NORMAL;
                end
                // wakes are simply not looked at here
            end
            OMC_NORMAL:
            begin
                if (cmd_valid && cmd_is_mode)
                begin
                    if (cmd_mode == MODE_STOP)
                        nxt_state = OMC_STOP;
                    else if (cmd_mode == MODE_SLEEP)
                        nxt_state = OMC_SLEEP;
                end
            end
            OMC_STOP:
            begin
                if (cmd_valid && cmd_is_mode)
                begin
                    if (cmd_mode == MODE_NORMAL)
                        nxt_state = OMC_NORMAL;
                    else if (cmd_mode == MODE_SLEEP)
                    begin
                        nxt_fail  = 1'b1;
                        nxt_state = OMC_RESTART;
                    end
                    else if (cmd_mode != MODE_STOP)
                        nxt_fail = 1'b1;
                end
                if (cmd_valid && cmd_is_mode &&
                    cmd_mode != MODE_SLEEP && cmd_mode != MODE_NORMAL)
                    nxt_field = field_ff;
            end
            OMC_SLEEP:
            begin
                if (wake)
                begin
                    nxt_state = OMC_RESTART;
                    nxt_wseen = 1'b1;
                end
                if (cmd_valid)
                begin
                    nxt_fail  = 1'b1;
                    nxt_field = field_ff;
                end
            end
            OMC_RESTART:
            begin
                nxt_field = MODE_FIELD_RST;
                if (failure)
                    nxt_dly = '0;
                else if (dly_ff == DLY_W'(RESET_DELAY_CYC - 1))
                begin
                    nxt_state = OMC_NORMAL;
                    nxt_dly   = '0;
                end
                else
                    nxt_dly = dly_ff + DLY_W'(1);
            end
            OMC_FAILSAFE:
            begin
                nxt_field = MODE_FIELD_RST;
                if (wake && !thermal_shutdown_level_two)
                begin
                    nxt_state = OMC_RESTART;
                    nxt_wseen = 1'b1;
                end
            end
        endcase
        // failures outrank mode requests
        if (state_ff != OMC_INIT && state_ff != OMC_FAILSAFE)
        begin
            if (thermal_shutdown_level_two || rail_short)
            begin
                nxt_state = OMC_FAILSAFE;
                nxt_dly   = '0;
            end
            else if (state_ff != OMC_SLEEP &&
                     state_ff != OMC_RESTART &&
                     ((wd_fail && !dev_ff) || rail_uv))
            begin
                nxt_state = OMC_RESTART;
                nxt_dly   = '0;
            end
        end
        if (state_ff == OMC_INIT && cmd_valid && thermal_shutdown_level_two)
            nxt_state = OMC_FAILSAFE;
        // field must not name a mode the machine is leaving
        if (nxt_state == OMC_RESTART || nxt_state == OMC_FAILSAFE)
            nxt_field = MODE_FIELD_RST;
        if (soft_rst)
        begin
            nxt_state = OMC_INIT;
            nxt_field = MODE_FIELD_RST;
            nxt_dly   = '0;
            nxt_dev   = 1'b0;
        end
        // a fresh failure is latched; only srst clears it, soft reset does not
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_ff <= OMC_INIT;
            field_ff <= MODE_FIELD_RST;
            dly_ff   <= '0;
            dev_ff   <= 1'b0;
            fail_ff  <= 1'b0;
            wseen_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            state_ff <= nxt_state;
            field_ff <= nxt_field;
            dly_ff   <= nxt_dly;
            dev_ff   <= nxt_dev;
            fail_ff  <= nxt_fail;
            wseen_ff <= nxt_wseen;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign mode_state       = state_ff;
    assign mode_field       = field_ff;
    assign main_supply_rail = (state_ff != OMC_SLEEP) &&
                              (state_ff != OMC_FAILSAFE);
    // host runs in init so that it can send the first command
    assign host_rst_n       = (state_ff != OMC_RESTART) &&
                              (state_ff != OMC_FAILSAFE) &&
                              (state_ff != OMC_SLEEP);
    assign dev_mode         = dev_ff;
    assign wd_halt          = dev_ff;
    assign spi_fail         = fail_ff;
    assign wake_seen        = wseen_ff;

    // ************************************************************
    // checks
    // ************************************************************
    a_restart_holds_rst: assert property (
        @(posedge ref_clk) disable iff (srst)
        state_ff == OMC_RESTART |-> !host_rst_n)
        else $error("host not held in reset during restart");
    a_sleep_rail_off: assert property (
        @(posedge ref_clk) disable iff (srst)
        state_ff == OMC_SLEEP |-> !main_supply_rail)
        else $error("main rail on in sleep");
    a_stop_rail_on: assert property (
        @(posedge ref_clk) disable iff (srst)
        state_ff == OMC_STOP |-> main_supply_rail)
        else $error("main rail off in stop");
    a_restart_field_zero: assert property (
        @(posedge ref_clk) disable iff (srst)
        clk_en && state_ff == OMC_RESTART && !soft_rst
        |=> field_ff == MODE_FIELD_RST)
        else $error("mode field not cleared in restart");
    a_stop_sleep_fail: assert property (
        @(posedge ref_clk) disable iff (srst)
        clk_en && state_ff == OMC_STOP && cmd_valid && cmd_is_mode &&
        cmd_mode == MODE_SLEEP && !soft_rst |=> spi_fail)
        else $error("stop to sleep did not flag");
    a_init_cmd_normal: assert property (
        @(posedge ref_clk) disable iff (srst)
        clk_en && state_ff == OMC_INIT && cmd_valid && !soft_rst &&
        !thermal_shutdown_level_two |=> state_ff == OMC_NORMAL)
        else $error("command in init did not reach normal");
    a_soft_rst_init: assert property (
        @(posedge ref_clk) disable iff (srst)
        clk_en && soft_rst |=> state_ff == OMC_INIT)
        else $error("soft reset did not enter init");
    a_failsafe_entry: assert property (
        @(posedge ref_clk) disable iff (srst)
        clk_en && !soft_rst && rail_short && state_ff == OMC_NORMAL
        |=> state_ff == OMC_FAILSAFE && !main_supply_rail)
        else $error("rail short did not enter failsafe");
    a_dev_halts_wd: assert property (
        @(posedge ref_clk) disable iff (srst)
        clk_en && dev_mode && wd_fail && state_ff == OMC_NORMAL &&
        !rail_uv |=> state_ff != OMC_RESTART && wd_halt)
        else $error("watchdog failure acted on in development");
    a_sleep_wake_restart: assert property (
        @(posedge ref_clk) disable iff (srst)
        clk_en && !soft_rst && state_ff == OMC_SLEEP && wake &&
        !thermal_shutdown_level_two && !rail_short |=> state_ff == OMC_RESTART)
        else $error("wake in sleep did not restart");
    a_init_wake_ignored: assert property (
        @(posedge ref_clk) disable iff (srst)
        clk_en && state_ff == OMC_INIT && !cmd_valid
        |=> state_ff == OMC_INIT && !wake_seen)
        else $error("wake acted on in init");
    a_failsafe_hot_holds: assert property (
        @(posedge ref_clk) disable iff (srst)
        clk_en && !soft_rst && state_ff == OMC_FAILSAFE &&
        thermal_shutdown_level_two |=> state_ff == OMC_FAILSAFE)
        else $error("failsafe left while overtemperature present");
    a_restart_uv_holds: assert property (
        @(posedge ref_clk) disable iff (srst)
        clk_en && !soft_rst && state_ff == OMC_RESTART && rail_uv &&
        !thermal_shutdown_level_two && !rail_short
        |=> state_ff == OMC_RESTART && dly_ff == '0)
        else $error("restart left while undervoltage present");
    a_wd_fail_restart: assert property (
        @(posedge ref_clk) disable iff (srst)
        clk_en && !soft_rst && state_ff == OMC_NORMAL && wd_fail &&
        !dev_mode && !thermal_shutdown_level_two && !rail_short
        |=> state_ff == OMC_RESTART && field_ff == MODE_FIELD_RST)
        else $error("watchdog failure did not restart");
endmodule
`default_nettype wire

// File: verif/omc_host_model.sv
// host model: turns bench requests into decoded spi frames
`timescale 1ns/1ns
`default_nettype none
module omc_host_model
    import omc_pkg::*;
(
    input  wire logic       ref_clk,      // system clock
    input  wire logic       host_rst_n,   // low: host held silent
    input  wire logic       send,         // bench asks for a frame
    input  wire logic       send_is_mode, // frame writes mode field
    input  wire logic [1:0] send_mode,    // requested mode code
    output logic            cmd_valid,    // one frame, one cycle
    output logic            cmd_is_mode,  // mode write qualifier
    output logic [1:0]      cmd_mode      // mode code
);
    initial
    begin
        cmd_valid   = 1'b0;
        cmd_is_mode = 1'b0;
        cmd_mode    = 2'h0;
    end
    // a host in reset cannot talk; idle fields toggle so none look held
    always @(posedge ref_clk)
    begin
        if (send && host_rst_n)
        begin
            cmd_valid   <= 1'b1;
            cmd_is_mode <= send_is_mode;
            cmd_mode    <= send_mode;
        end
        else
        begin
            cmd_valid   <= 1'b0;
            cmd_is_mode <= ~cmd_is_mode;
            cmd_mode    <= ~cmd_mode;
        end
    end
endmodule
`default_nettype wire

// File: verif/omc_ctrl_tb.sv
// self-checking bench for the operating-mode controller
`timescale 1ns/1ns
`default_nettype none
module omc_ctrl_tb
    import omc_pkg::*;
;
    logic ref_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, soft_rst = 1'b0;
    logic wake_pin = 1'b0, test_pin = 1'b1, wd_fail = 1'b0;
    logic rail_uv = 1'b0, rail_short = 1'b0;
    logic thermal_shutdown_level_two = 1'b0;
    logic send = 1'b0, send_is_mode = 1'b0;
    logic [1:0] send_mode = 2'h0;
    logic cmd_valid, cmd_is_mode, main_supply_rail, host_rst_n;
    logic dev_mode, wd_halt, spi_fail, wake_seen;
    logic [1:0] cmd_mode, mode_field;
    logic [2:0] mode_state;
    int n_mismatch = 0, n_tests = 0;
    always #4 ref_clk = ~ref_clk;
    omc_host_model omc_host_model_inst (.ref_clk(ref_clk),
        .host_rst_n(host_rst_n), .send(send), .send_is_mode(send_is_mode),
        .send_mode(send_mode), .cmd_valid(cmd_valid),
        .cmd_is_mode(cmd_is_mode), .cmd_mode(cmd_mode));
    omc_ctrl omc_ctrl_inst (.ref_clk(ref_clk), .srst(srst),
        .clk_en(clk_en), .soft_rst(soft_rst), .cmd_valid(cmd_valid),
        .cmd_is_mode(cmd_is_mode), .cmd_mode(cmd_mode),
        .wake_pin(wake_pin), .test_pin(test_pin), .wd_fail(wd_fail),
        .rail_uv(rail_uv), .rail_short(rail_short),
        .thermal_shutdown_level_two(thermal_shutdown_level_two),
        .mode_state(mode_state), .mode_field(mode_field),
        .main_supply_rail(main_supply_rail), .host_rst_n(host_rst_n),
        .dev_mode(dev_mode), .wd_halt(wd_halt), .spi_fail(spi_fail),
        .wake_seen(wake_seen));
    // ********************
    // helpers
    // ********************
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task automatic cmd(input logic m, input logic [1:0] c);
        @(posedge ref_clk);
        send <= 1'b1;
        send_is_mode <= m;
        send_mode <= c;
        @(posedge ref_clk);
        send <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_mode(input logic [2:0] exp, input int lim,
                             output int n);
        n = 0;
        #1;
        while (mode_state !== exp && n < lim)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk(mode_state, exp);
    endtask
    // exit timing is judged from the moment the cause went away
    task automatic rst_exit();
        int n;
        wait_mode(OMC_NORMAL, RESET_DELAY_CYC + 20, n);
        chk({2'h0, n >= RESET_DELAY_CYC - 3 && n <= RESET_DELAY_CYC + 3},
            3'h1);
        chk({2'h0, host_rst_n}, 3'h1);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ********************
    // scenarios
    // ********************
    task automatic t_reset();
        chk(mode_state, OMC_INIT);
        chk({1'b0, main_supply_rail, host_rst_n}, 3'h3);
        chk({1'b0, spi_fail, dev_mode}, 3'h0);
    endtask
    task automatic t_init();
        @(posedge ref_clk);
        wake_pin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        wake_pin <= 1'b0;
        #1;
        chk(mode_state, OMC_INIT);
        cmd(1'b0, MODE_SLEEP);
        chk(mode_state, OMC_NORMAL);
    endtask
    task automatic t_stop();
        cmd(1'b1, MODE_STOP);
        chk(mode_state, OMC_STOP);
        chk({main_supply_rail, mode_field}, {1'b1, MODE_STOP});
        cmd(1'b1, MODE_SLEEP);
        chk(mode_state, OMC_RESTART);
        chk({2'h0, spi_fail}, 3'h1);
        chk({2'h0, host_rst_n}, 3'h0);
        chk({1'b0, mode_field}, {1'b0, MODE_FIELD_RST});
        rst_exit();
        cmd(1'b1, MODE_STOP);
        cmd(1'b1, MODE_STOP);
        chk(mode_state, OMC_STOP);
        cmd(1'b1, MODE_NORMAL);
        chk(mode_state, OMC_NORMAL);
        cmd(1'b1, MODE_RESET);
        chk(mode_state, OMC_NORMAL);
        chk({1'b0, mode_field}, {1'b0, MODE_NORMAL});
    endtask
    task automatic t_sleep();
        int n;
        cmd(1'b1, MODE_SLEEP);
        chk(mode_state, OMC_SLEEP);
        chk({1'b0, main_supply_rail, host_rst_n}, 3'h0);
        @(posedge ref_clk);
        wake_pin <= 1'b1;
        wait_mode(OMC_RESTART, 6, n);
        chk({2'h0, wake_seen}, 3'h1);
        @(posedge ref_clk);
        wake_pin <= 1'b0;
        rst_exit();
    endtask
    task automatic t_fail();
        int n;
        @(posedge ref_clk);
        wd_fail <= 1'b1;
        @(posedge ref_clk);
        wd_fail <= 1'b0;
        wait_mode(OMC_RESTART, 3, n);
        chk({2'h0, wake_seen}, 3'h0);
        rst_exit();
        @(posedge ref_clk);
        rail_uv <= 1'b1;
        wait_mode(OMC_RESTART, 4, n);
        repeat (1400) @(posedge ref_clk);
        rail_uv <= 1'b0;
        #1;
        chk(mode_state, OMC_RESTART);
        rst_exit();
    endtask
    task automatic t_safe();
        int n;
        @(posedge ref_clk);
        rail_short <= 1'b1;
        wait_mode(OMC_FAILSAFE, 4, n);
        chk({2'h0, main_supply_rail}, 3'h0);
        @(posedge ref_clk);
        rail_short <= 1'b0;
        thermal_shutdown_level_two <= 1'b1;
        wake_pin <= 1'b1;
        repeat (8) @(posedge ref_clk);
        thermal_shutdown_level_two <= 1'b0;
        #1;
        chk(mode_state, OMC_FAILSAFE);
        wait_mode(OMC_RESTART, 8, n);
        chk({2'h0, wake_seen}, 3'h1);
        @(posedge ref_clk);
        wake_pin <= 1'b0;
        rst_exit();
    endtask
    task automatic t_dev();
        int n;
        @(posedge ref_clk);
        test_pin <= 1'b0;
        soft_rst <= 1'b1;
        @(posedge ref_clk);
        soft_rst <= 1'b0;
        wait_mode(OMC_INIT, 3, n);
        repeat (4) @(posedge ref_clk);
        #1;
        chk({1'b0, dev_mode, wd_halt}, 3'h3);
        cmd(1'b0, MODE_NORMAL);
        @(posedge ref_clk);
        wd_fail <= 1'b1;
        @(posedge ref_clk);
        wd_fail <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk(mode_state, OMC_NORMAL);
        cmd(1'b1, MODE_STOP);
        chk(mode_state, OMC_STOP);
    endtask
    initial
    begin
        #(30000 * 8);
        n_mismatch++;
        end_sim();
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        t_reset();
        t_init();
        t_stop();
        t_sleep();
        t_fail();
        t_safe();
        t_dev();
        end_sim();
    end
endmodule
`default_nettype wire
